// *** logic/ddcfg_pkg.sv ***
/*
  Constants for the downconverter configuration decode: register indices,
  field positions, reset values and the bus geometry.
  Assumes a single clock domain and a 32-bit APB slave in front of it.
*/
package ddcfg_pkg;

  // APB byte address is four times the register index
  localparam int APB_AW = 14;
  localparam int REG_W = 8;
  localparam int IDX_W = 12;
  localparam int NUM_REGS = 15;

  localparam logic [IDX_W-1:0] IDX_DC_SELECT = 12'h200;
  localparam logic [IDX_W-1:0] IDX_CHIP_DECIMATION = 12'h201;
  localparam logic [IDX_W-1:0] IDX_DECODE_STATUS = 12'h202;
  localparam logic [IDX_W-1:0] IDX_DC0_CONTROL = 12'h310;
  localparam logic [IDX_W-1:0] IDX_DC0_ROUTING = 12'h311;
  localparam logic [IDX_W-1:0] IDX_DC0_TUNING_LO = 12'h314;
  localparam logic [IDX_W-1:0] IDX_DC0_TUNING_HI = 12'h315;
  localparam logic [IDX_W-1:0] IDX_DC0_PHASE_LO = 12'h320;
  localparam logic [IDX_W-1:0] IDX_DC0_PHASE_HI = 12'h321;
  localparam logic [IDX_W-1:0] IDX_DC1_CONTROL = 12'h330;
  localparam logic [IDX_W-1:0] IDX_DC1_ROUTING = 12'h331;
  localparam logic [IDX_W-1:0] IDX_DC1_TUNING_LO = 12'h334;
  localparam logic [IDX_W-1:0] IDX_DC1_TUNING_HI = 12'h335;
  localparam logic [IDX_W-1:0] IDX_DC1_PHASE_LO = 12'h340;
  localparam logic [IDX_W-1:0] IDX_DC1_PHASE_HI = 12'h341;

  // Storage slots, in the order of the table below
  localparam int SLOT_DC_SELECT = 0;
  localparam int SLOT_CHIP_DECIMATION = 1;
  localparam int SLOT_DECODE_STATUS = 2;
  localparam int SLOT_DC0_CONTROL = 3;
  localparam int SLOT_DC0_ROUTING = 4;
  localparam int SLOT_DC0_TUNING_LO = 5;
  localparam int SLOT_DC0_TUNING_HI = 6;
  localparam int SLOT_DC0_PHASE_LO = 7;
  localparam int SLOT_DC0_PHASE_HI = 8;
  localparam int SLOT_DC1_CONTROL = 9;
  localparam int SLOT_DC1_ROUTING = 10;
  localparam int SLOT_DC1_TUNING_LO = 11;
  localparam int SLOT_DC1_TUNING_HI = 12;
  localparam int SLOT_DC1_PHASE_LO = 13;
  localparam int SLOT_DC1_PHASE_HI = 14;

  localparam logic [IDX_W-1:0] REG_INDEX [NUM_REGS] = '{
    IDX_DC_SELECT, IDX_CHIP_DECIMATION, IDX_DECODE_STATUS,
    IDX_DC0_CONTROL, IDX_DC0_ROUTING, IDX_DC0_TUNING_LO, IDX_DC0_TUNING_HI,
    IDX_DC0_PHASE_LO, IDX_DC0_PHASE_HI,
    IDX_DC1_CONTROL, IDX_DC1_ROUTING, IDX_DC1_TUNING_LO, IDX_DC1_TUNING_HI,
    IDX_DC1_PHASE_LO, IDX_DC1_PHASE_HI
  };

  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  // Downconverter selection fields
  localparam int SEL_COUNT_LSB = 0;
  localparam int SEL_COUNT_W = 2;
  localparam int SEL_I_ONLY_BIT = 5;

  // Chip decimation codes
  localparam logic [REG_W-1:0] CHIP_DEC_BY2 = 8'h01;
  localparam logic [REG_W-1:0] CHIP_DEC_BY4 = 8'h02;
  localparam logic [REG_W-1:0] CHIP_DEC_BY8 = 8'h03;
  localparam logic [REG_W-1:0] CHIP_DEC_BY16 = 8'h04;

  // Downconverter control fields
  localparam int CTL_MIXER_BIT = 7;
  localparam int CTL_GAIN_BIT = 6;
  localparam int CTL_IF_LSB = 4;
  localparam int CTL_REAL_BIT = 3;
  localparam int CTL_CHAIN_LSB = 0;

  // Input routing fields: set means converter channel B
  localparam int ROUTE_I_BIT = 0;
  localparam int ROUTE_Q_BIT = 2;

  // Status fields
  localparam int STAT_CHIP_VALID_BIT = 0;
  localparam int STAT_DC0_MISMATCH_BIT = 1;
  localparam int STAT_DC1_MISMATCH_BIT = 2;
  localparam int STAT_VC_LSB = 4;

  typedef enum logic [1:0] {
    ddcfg_chain_two = 2'b00,
    ddcfg_chain_three = 2'b01,
    ddcfg_chain_four = 2'b10,
    ddcfg_chain_final_only = 2'b11
  } ddcfg_chain_t;

endpackage : ddcfg_pkg

// *** logic/ddcfg_chip_decode.sv ***
/*
  Chip-level decode: downconverter count, I/Q or I-only delivery, virtual
  converter count and the chip decimation factor, all registered.
  Assumes its inputs are register contents on the same clock.
*/
`timescale 1ns/1ns
module ddcfg_chip_decode (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ddcfg_pkg::REG_W-1:0] select_reg,
  input wire logic [ddcfg_pkg::REG_W-1:0] decimation_reg,
  output logic [1:0] dc_enable,
  output logic [2:0] num_enabled_dc,
  output logic iq_outputs,
  output logic [3:0] virtual_converter_count,
  output logic [4:0] chip_decimation_factor,
  output logic chip_decimation_valid
);
  import ddcfg_pkg::*;

  logic [1:0] count_code;
  logic [2:0] next_num;
  logic [4:0] next_factor;

  assign count_code = select_reg[SEL_COUNT_LSB +: SEL_COUNT_W];
  // Code 3 asks for four; only two are present here, the count still says four
  assign next_num = (count_code == 2'h3) ? 3'h4 : {1'b0, count_code};

  always_comb begin
    unique case (decimation_reg)
      CHIP_DEC_BY2: next_factor = 5'h02;
      CHIP_DEC_BY4: next_factor = 5'h04;
      CHIP_DEC_BY8: next_factor = 5'h08;
      CHIP_DEC_BY16: next_factor = 5'h10;
      default: next_factor = 5'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_enable <= 2'h0;
      num_enabled_dc <= 3'h0;
      iq_outputs <= 1'b0;
      virtual_converter_count <= 4'h0;
    end else begin
      dc_enable <= {count_code >= 2'h2, count_code >= 2'h1};
      num_enabled_dc <= next_num;
      iq_outputs <= !select_reg[SEL_I_ONLY_BIT];
      virtual_converter_count <= select_reg[SEL_I_ONLY_BIT] ?
        {1'b0, next_num} : {next_num, 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_decimation_factor <= 5'h00;
      chip_decimation_valid <= 1'b0;
    end else begin
      chip_decimation_factor <= next_factor;
      chip_decimation_valid <= (next_factor != 5'h00);
    end
  end

endmodule : ddcfg_chip_decode

// *** logic/ddcfg_chain_decode.sv ***
/*
  Per-downconverter decode of control and routing into mixer, gain,
  output type, half-band chain and input selection; registered outputs.
  Assumes register contents on the same clock; instantiated once per path.
*/
`timescale 1ns/1ns
module ddcfg_chain_decode (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ddcfg_pkg::REG_W-1:0] control_reg,
  input wire logic [ddcfg_pkg::REG_W-1:0] routing_reg,
  input wire logic enabled,
  input wire logic [4:0] chip_factor,
  output logic mixer_complex,
  output logic gain_6db,
  output logic [1:0] if_mode,
  output logic real_output,
  output logic first_halfband_enable,
  output logic second_halfband_enable,
  output logic third_halfband_enable,
  output logic final_halfband_enable,
  output logic final_downsample_bypass,
  output logic quarter_rate_upconvert,
  output logic i_from_channel_b,
  output logic q_from_channel_b,
  output logic [4:0] decimation,
  output logic decimation_mismatch
);
  import ddcfg_pkg::*;

  ddcfg_chain_t chain;
  logic is_real;
  logic [2:0] stages;
  logic [4:0] next_decimation;

  assign chain = ddcfg_chain_t'(control_reg[CTL_CHAIN_LSB +: 2]);
  assign is_real = control_reg[CTL_REAL_BIT];

  always_comb begin
    unique case (chain)
      ddcfg_chain_final_only: stages = 3'h1;
      ddcfg_chain_two: stages = 3'h2;
      ddcfg_chain_three: stages = 3'h3;
      ddcfg_chain_four: stages = 3'h4;
    endcase
  end

  // Real output skips the final downsample, halving the path decimation
  assign next_decimation = is_real ? 5'(5'h01 << (stages - 3'h1)) :
    5'(5'h01 << stages);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mixer_complex <= 1'b0;
      gain_6db <= 1'b0;
      if_mode <= 2'h0;
      real_output <= 1'b0;
    end else begin
      mixer_complex <= control_reg[CTL_MIXER_BIT];
      gain_6db <= control_reg[CTL_GAIN_BIT];
      if_mode <= control_reg[CTL_IF_LSB +: 2];
      real_output <= is_real;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_halfband_enable <= 1'b0;
      second_halfband_enable <= 1'b0;
      third_halfband_enable <= 1'b0;
      final_halfband_enable <= 1'b1;
      final_downsample_bypass <= 1'b0;
      quarter_rate_upconvert <= 1'b0;
    end else begin
      first_halfband_enable <= (stages >= 3'h4);
      second_halfband_enable <= (stages >= 3'h3);
      third_halfband_enable <= (stages >= 3'h2);
      final_halfband_enable <= 1'b1;
      final_downsample_bypass <= is_real;
      quarter_rate_upconvert <= is_real;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i_from_channel_b <= 1'b0;
      q_from_channel_b <= 1'b0;
      decimation <= 5'h00;
      decimation_mismatch <= 1'b0;
    end else begin
      i_from_channel_b <= routing_reg[ROUTE_I_BIT];
      q_from_channel_b <= routing_reg[ROUTE_Q_BIT];
      decimation <= next_decimation;
      decimation_mismatch <= enabled && (next_decimation != chip_factor);
    end
  end

endmodule : ddcfg_chain_decode

// *** logic/ddcfg_top.sv ***
/*
  Register bank and decode for two digital downconverters behind an APB
  slave: selection, chip decimation, per-path control, routing, tuning and
  phase words, plus a read-only decode status register.
  Assumes a single pclk domain; zero-wait APB, byte address = index * 4.
*/
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
module ddcfg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ddcfg_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] dc_enable,
  output logic [2:0] num_enabled_dc,
  output logic iq_outputs,
  output logic [3:0] virtual_converter_count,
  output logic [4:0] chip_decimation_factor,
  output logic chip_decimation_valid,
  output logic dc0_mixer_complex,
  output logic dc0_gain_6db,
  output logic [1:0] dc0_if_mode,
  output logic dc0_real_output,
  output logic dc0_first_halfband_filter_enable,
  output logic dc0_second_halfband_filter_enable,
  output logic dc0_third_halfband_filter_enable,
  output logic dc0_final_halfband_filter_enable,
  output logic dc0_final_downsample_bypass,
  output logic dc0_quarter_rate_upconvert,
  output logic dc0_drop_quadrature,
  output logic dc0_i_from_channel_b,
  output logic dc0_q_from_channel_b,
  output logic [4:0] dc0_decimation,
  output logic [15:0] dc0_frequency_tuning_word,
  output logic [15:0] dc0_phase_offset_word,
  output logic dc1_mixer_complex,
  output logic dc1_gain_6db,
  output logic [1:0] dc1_if_mode,
  output logic dc1_real_output,
  output logic dc1_first_halfband_filter_enable,
  output logic dc1_second_halfband_filter_enable,
  output logic dc1_third_halfband_filter_enable,
  output logic dc1_final_halfband_filter_enable,
  output logic dc1_final_downsample_bypass,
  output logic dc1_quarter_rate_upconvert,
  output logic dc1_drop_quadrature,
  output logic dc1_i_from_channel_b,
  output logic dc1_q_from_channel_b,
  output logic [4:0] dc1_decimation,
  output logic [15:0] dc1_frequency_tuning_word,
  output logic [15:0] dc1_phase_offset_word
);
  import ddcfg_pkg::*;

  logic [REG_W-1:0] regs [NUM_REGS];
  logic [IDX_W-1:0] access_index;
  logic aligned;
  logic hit;
  logic [3:0] hit_slot;
  logic setup_phase;
  logic access_phase;
  logic write_ok;
  logic [REG_W-1:0] status_value;
  logic dc0_mismatch;
  logic dc1_mismatch;

  assign access_index = paddr[APB_AW-1:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;

  // Register index lookup over the fixed table
  always_comb begin
    hit = 1'b0;
    hit_slot = 4'h0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (aligned && (access_index == REG_INDEX[i])) begin
        hit = 1'b1;
        hit_slot = 4'(i);
      end
    end
  end

  // Status is computed, so writes to it are silently dropped
  assign write_ok = access_phase && pwrite && hit && pstrb[0] &&
    (hit_slot != 4'(SLOT_DECODE_STATUS));

  assign status_value = {virtual_converter_count, 1'b0, dc1_mismatch, dc0_mismatch,
    chip_decimation_valid};

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (write_ok) begin
      regs[hit_slot] <= pwdata[REG_W-1:0];
    end
  end

  // Read data and error are set up in the setup cycle, so they come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= !hit;
      if (!hit || pwrite) begin
        prdata <= 32'h0000_0000;
      end else if (hit_slot == 4'(SLOT_DECODE_STATUS)) begin
        prdata <= {24'h00_0000, status_value};
      end else begin
        prdata <= {24'h00_0000, regs[hit_slot]};
      end
    end
  end

  ddcfg_chip_decode u_chip (
    .pclk(pclk),
    .presetn(presetn),
    .select_reg(regs[SLOT_DC_SELECT]),
    .decimation_reg(regs[SLOT_CHIP_DECIMATION]),
    .dc_enable(dc_enable),
    .num_enabled_dc(num_enabled_dc),
    .iq_outputs(iq_outputs),
    .virtual_converter_count(virtual_converter_count),
    .chip_decimation_factor(chip_decimation_factor),
    .chip_decimation_valid(chip_decimation_valid)
  );

  ddcfg_chain_decode u_dc0 (
    .pclk(pclk),
    .presetn(presetn),
    .control_reg(regs[SLOT_DC0_CONTROL]),
    .routing_reg(regs[SLOT_DC0_ROUTING]),
    .enabled(dc_enable[0]),
    .chip_factor(chip_decimation_factor),
    .mixer_complex(dc0_mixer_complex),
    .gain_6db(dc0_gain_6db),
    .if_mode(dc0_if_mode),
    .real_output(dc0_real_output),
    .first_halfband_enable(dc0_first_halfband_filter_enable),
    .second_halfband_enable(dc0_second_halfband_filter_enable),
    .third_halfband_enable(dc0_third_halfband_filter_enable),
    .final_halfband_enable(dc0_final_halfband_filter_enable),
    .final_downsample_bypass(dc0_final_downsample_bypass),
    .quarter_rate_upconvert(dc0_quarter_rate_upconvert),
    .i_from_channel_b(dc0_i_from_channel_b),
    .q_from_channel_b(dc0_q_from_channel_b),
    .decimation(dc0_decimation),
    .decimation_mismatch(dc0_mismatch)
  );

  ddcfg_chain_decode u_dc1 (
    .pclk(pclk),
    .presetn(presetn),
    .control_reg(regs[SLOT_DC1_CONTROL]),
    .routing_reg(regs[SLOT_DC1_ROUTING]),
    .enabled(dc_enable[1]),
    .chip_factor(chip_decimation_factor),
    .mixer_complex(dc1_mixer_complex),
    .gain_6db(dc1_gain_6db),
    .if_mode(dc1_if_mode),
    .real_output(dc1_real_output),
    .first_halfband_enable(dc1_first_halfband_filter_enable),
    .second_halfband_enable(dc1_second_halfband_filter_enable),
    .third_halfband_enable(dc1_third_halfband_filter_enable),
    .final_halfband_enable(dc1_final_halfband_filter_enable),
    .final_downsample_bypass(dc1_final_downsample_bypass),
    .quarter_rate_upconvert(dc1_quarter_rate_upconvert),
    .i_from_channel_b(dc1_i_from_channel_b),
    .q_from_channel_b(dc1_q_from_channel_b),
    .decimation(dc1_decimation),
    .decimation_mismatch(dc1_mismatch)
  );

  // Quadrature dropped whenever the path delivers a real stream
  assign dc0_drop_quadrature = dc0_real_output;
  assign dc1_drop_quadrature = dc1_real_output;

  // Words are registered so the datapath sees them only after the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc0_frequency_tuning_word <= 16'h0000;
      dc0_phase_offset_word <= 16'h0000;
    end else begin
      dc0_frequency_tuning_word <= {regs[SLOT_DC0_TUNING_HI],
        regs[SLOT_DC0_TUNING_LO]};
      dc0_phase_offset_word <= {regs[SLOT_DC0_PHASE_HI],
        regs[SLOT_DC0_PHASE_LO]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc1_frequency_tuning_word <= 16'h0000;
      dc1_phase_offset_word <= 16'h0000;
    end else begin
      dc1_frequency_tuning_word <= {regs[SLOT_DC1_TUNING_HI],
        regs[SLOT_DC1_TUNING_LO]};
      dc1_phase_offset_word <= {regs[SLOT_DC1_PHASE_HI],
        regs[SLOT_DC1_PHASE_LO]};
    end
  end

endmodule : ddcfg_top

// *** testbench/ddcfg_top_sva.sv ***
/*
  Checker for the downconverter configuration decode top: decode timing,
  filter chain consistency and read data shape.
  Assumes a single pclk domain; bound to ddcfg_top by the statement below.
*/
`timescale 1ns/1ns
module ddcfg_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ddcfg_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic [3:0] virtual_converter_count,
  input wire logic [2:0] num_enabled_dc,
  input wire logic iq_outputs,
  input wire logic [4:0] chip_decimation_factor,
  input wire logic chip_decimation_valid,
  input wire logic dc0_mixer_complex,
  input wire logic dc0_gain_6db,
  input wire logic dc0_real_output,
  input wire logic dc0_second_halfband_filter_enable,
  input wire logic dc0_third_halfband_filter_enable,
  input wire logic dc0_final_halfband_filter_enable,
  input wire logic dc0_final_downsample_bypass,
  input wire logic dc0_quarter_rate_upconvert,
  input wire logic dc0_drop_quadrature,
  input wire logic dc1_final_halfband_filter_enable
);
  import ddcfg_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr(logic [IDX_W-1:0] idx);
    psel && penable && pwrite && pstrb[0] && paddr == {idx, 2'b00};
  endsequence
  // Decode lags the store by one edge, so outputs are looked at two edges on
  property p_ctl_apply;
    s_wr(IDX_DC0_CONTROL) |-> ##2 dc0_mixer_complex == $past(pwdata[7], 2)
      && dc0_gain_6db == $past(pwdata[6], 2) && dc0_real_output == $past(pwdata[3], 2);
  endproperty
  a_ctl_apply: assert property (p_ctl_apply) else $error("control decode wrong");
  property p_dec_by2;
    s_wr(IDX_CHIP_DECIMATION) ##0 pwdata[7:0] == CHIP_DEC_BY2
      |-> ##2 chip_decimation_factor == 5'h02 && chip_decimation_valid;
  endproperty
  a_dec_by2: assert property (p_dec_by2) else $error("decimate by 2 wrong");
  property p_sel_i_only;
    s_wr(IDX_DC_SELECT) ##0 pwdata[7:0] == 8'h22 |-> ##2 num_enabled_dc == 3'h2 && !iq_outputs;
  endproperty
  a_sel_i_only: assert property (p_sel_i_only) else $error("I-only select wrong");
  property p_final_on;
    dc0_final_halfband_filter_enable && dc1_final_halfband_filter_enable;
  endproperty
  a_final_on: assert property (p_final_on) else $error("final filter off");
  property p_real_conv;
    dc0_final_downsample_bypass == dc0_real_output && dc0_drop_quadrature == dc0_real_output
      && dc0_quarter_rate_upconvert == dc0_real_output;
  endproperty
  a_real_conv: assert property (p_real_conv) else $error("real conversion wrong");
  property p_third;
    dc0_second_halfband_filter_enable |-> dc0_third_halfband_filter_enable;
  endproperty
  a_third: assert property (p_third) else $error("third filter off");
  property p_vc;
    virtual_converter_count == (iq_outputs ? {num_enabled_dc, 1'b0} : {1'b0, num_enabled_dc});
  endproperty
  a_vc: assert property (p_vc) else $error("virtual count wrong");
  property p_read_hi;
    psel && penable && !pwrite |-> prdata[31:8] == 24'h000000;
  endproperty
  a_read_hi: assert property (p_read_hi) else $error("read upper bits set");
  property p_reset_zero;
    $rose(presetn) |-> ##1 virtual_converter_count == 4'h0 && chip_decimation_factor == 5'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset state wrong");
endmodule : ddcfg_top_sva

bind ddcfg_top ddcfg_top_sva i_sva (.*);

// *** testbench/test_downconverter_config_decode.sv ***
/*
  Self-checking bench for the downconverter configuration decode.
  Assumes ddcfg_pkg, the design and its checker are compiled first.
*/
`timescale 1ns/1ns
module test_downconverter_config_decode;
  import ddcfg_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [3:0] pstrb = 4'hF, virtual_converter_count;
  logic pready, pslverr, iq_outputs, chip_decimation_valid, erv;
  logic [1:0] dc_enable, dc0_if_mode, dc1_if_mode;
  logic [2:0] num_enabled_dc;
  logic [4:0] chip_decimation_factor, dc0_decimation, dc1_decimation;
  logic [15:0] dc0_frequency_tuning_word, dc0_phase_offset_word;
  logic [15:0] dc1_frequency_tuning_word, dc1_phase_offset_word;
  logic dc0_mixer_complex, dc0_gain_6db, dc0_real_output, dc0_first_halfband_filter_enable;
  logic dc0_second_halfband_filter_enable, dc0_third_halfband_filter_enable;
  logic dc0_final_halfband_filter_enable, dc0_final_downsample_bypass;
  logic dc0_quarter_rate_upconvert, dc0_drop_quadrature, dc0_i_from_channel_b;
  logic dc0_q_from_channel_b, dc1_mixer_complex, dc1_gain_6db, dc1_real_output;
  logic dc1_first_halfband_filter_enable, dc1_second_halfband_filter_enable;
  logic dc1_third_halfband_filter_enable, dc1_final_halfband_filter_enable;
  logic dc1_final_downsample_bypass, dc1_quarter_rate_upconvert, dc1_drop_quadrature;
  logic dc1_i_from_channel_b, dc1_q_from_channel_b;
  integer seed = 87;
  int compares = 0, miscompares = 0, cycles = 0;
  logic [7:0] v, b [8];
  logic [7:0] sel_tab [6] = '{8'h01, 8'h02, 8'h22, 8'h00, 8'h03, 8'h23};
  logic [7:0] ctl_tab [8] = '{8'h83, 8'h80, 8'h89, 8'h49, 8'h40, 8'h4A, 8'h41, 8'h03};
  logic [7:0] rt_tab [3] = '{8'h04, 8'h00, 8'h05};
  logic [IDX_W-1:0] w_tab [8] = '{IDX_DC0_TUNING_LO, IDX_DC0_TUNING_HI, IDX_DC0_PHASE_LO,
    IDX_DC0_PHASE_HI, IDX_DC1_TUNING_LO, IDX_DC1_TUNING_HI, IDX_DC1_PHASE_LO, IDX_DC1_PHASE_HI};
  wire [16:0] obs0 = {dc0_mixer_complex, dc0_gain_6db, dc0_if_mode, dc0_real_output,
    dc0_first_halfband_filter_enable, dc0_second_halfband_filter_enable,
    dc0_third_halfband_filter_enable, dc0_final_halfband_filter_enable,
    dc0_final_downsample_bypass, dc0_quarter_rate_upconvert, dc0_drop_quadrature, dc0_decimation};
  wire [16:0] obs1 = {dc1_mixer_complex, dc1_gain_6db, dc1_if_mode, dc1_real_output,
    dc1_first_halfband_filter_enable, dc1_second_halfband_filter_enable,
    dc1_third_halfband_filter_enable, dc1_final_halfband_filter_enable,
    dc1_final_downsample_bypass, dc1_quarter_rate_upconvert, dc1_drop_quadrature, dc1_decimation};

  ddcfg_top i_dut (.*);

  always #20 pclk = ~pclk;

  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      stop_test();
    end
  end

  // One bit wider than the bus so the error flag travels with read data
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Upper write data bits are random junk that must never be stored
  task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] d,
                     input logic [3:0] st, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= ($random(seed) << 8) | d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'hF, rdv, erv);
    repeat (2) @(negedge pclk);
  endtask : wr

  function automatic logic [9:0] exp_sel(input logic [7:0] s);
    logic [2:0] num;
    num = s[1:0] == 2'b11 ? 3'h4 : {1'b0, s[1:0]};
    return {s[1:0] >= 2'h2, s[1:0] != 2'h0, num, !s[5], !s[5] ? {num, 1'b0} : {1'b0, num}};
  endfunction : exp_sel

  // Real output skips the final downsample, so it decimates one stage less
  function automatic logic [16:0] exp_ctl(input logic [7:0] c);
    int st;
    logic [3:0] en;
    st = c[1:0] == 2'b11 ? 1 : int'(c[1:0]) + 2;
    en = 4'hF >> (4 - st);
    return {c[7], c[6], c[5:4], c[3], en, c[3], c[3], c[3], 5'(1 << (st - int'(c[3])))};
  endfunction : exp_ctl

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("final enable", {dc0_final_halfband_filter_enable, dc1_final_halfband_filter_enable},
          32'h3);
    foreach (REG_INDEX[k]) begin
      apb(1'b0, REG_INDEX[k], 8'h00, 4'h0, rdv, erv);
      check("reset value", rdv, 32'h0);
    end
    for (int k = 0; k < 12; k++) begin
      v = k < 6 ? sel_tab[k] : 8'($random(seed));
      wr(IDX_DC_SELECT, v);
      check("select", {dc_enable, num_enabled_dc, iq_outputs, virtual_converter_count},
            exp_sel(v));
    end
    for (int k = 0; k < 10; k++) begin
      v = k < 6 ? 8'(k) : 8'($random(seed));
      wr(IDX_CHIP_DECIMATION, v);
      check("decimation", {chip_decimation_valid, chip_decimation_factor},
            (v >= 8'h01 && v <= 8'h04) ? {1'b1, 5'(1 << v)} : 32'h0);
    end
    for (int k = 0; k < 16; k++) begin
      v = k < 8 ? ctl_tab[k] : 8'($random(seed));
      wr(IDX_DC0_CONTROL, v);
      wr(IDX_DC1_CONTROL, ~v);
      check("dc0 control", obs0, exp_ctl(v));
      check("dc1 control", obs1, exp_ctl(~v));
    end
    for (int k = 0; k < 8; k++) begin
      v = k < 3 ? rt_tab[k] : 8'($random(seed));
      wr(IDX_DC0_ROUTING, v);
      wr(IDX_DC1_ROUTING, v ^ 8'h05);
      check("dc0 route", {dc0_q_from_channel_b, dc0_i_from_channel_b},
            {v[2], v[0]});
      check("dc1 route", {dc1_q_from_channel_b, dc1_i_from_channel_b},
            {!v[2], !v[0]});
    end
    for (int r = 0; r < 3; r++) begin
      foreach (w_tab[j]) begin
        b[j] = 8'($random(seed));
        wr(w_tab[j], b[j]);
      end
      check("dc0 tuning", dc0_frequency_tuning_word, {b[1], b[0]});
      check("dc0 phase", dc0_phase_offset_word, {b[3], b[2]});
      check("dc1 tuning", dc1_frequency_tuning_word, {b[5], b[4]});
      check("dc1 phase", dc1_phase_offset_word, {b[7], b[6]});
      foreach (w_tab[j]) begin
        apb(1'b0, w_tab[j], 8'h00, 4'h0, rdv, erv);
        check("readback", {erv, rdv}, {1'b0, 24'h0, b[j]});
      end
    end
    // Consistent setup: two paths with I and Q, chip and paths all decimate by 4
    wr(IDX_DC_SELECT, 8'h02);
    wr(IDX_CHIP_DECIMATION, CHIP_DEC_BY4);
    wr(IDX_DC0_CONTROL, 8'h80);
    wr(IDX_DC1_CONTROL, 8'h80);
    apb(1'b0, IDX_DECODE_STATUS, 8'h00, 4'h0, rdv, erv);
    check("status ok", {erv, rdv}, {1'b0, 24'h0, 8'h41});
    // Final-only chain on path 1 decimates by 2 and must be flagged
    wr(IDX_DC1_CONTROL, 8'h83);
    apb(1'b0, IDX_DECODE_STATUS, 8'h00, 4'h0, rdv, erv);
    check("status mismatch", {erv, rdv}, {1'b0, 24'h0, 8'h45});
    // A write without its low byte strobe must leave the register alone
    apb(1'b1, IDX_DC0_TUNING_LO, ~b[0], 4'hE, rdv, erv);
    apb(1'b0, IDX_DC0_TUNING_LO, 8'h00, 4'h0, rdv, erv);
    check("masked write", {erv, rdv}, {1'b0, 24'h0, b[0]});
    apb(1'b0, 12'h3FF, 8'h00, 4'h0, rdv, erv);
    check("unmapped read", {erv, rdv}, {1'b1, 32'h0});
    stop_test();
  end
endmodule : test_downconverter_config_decode
